// ==== hw/fast_timer_map.svh ====
/*
  Register offsets, field positions, reset values and timing counts for the
  fast timer output control block.
  Assumes inclusion by bare name from package and test files.
*/
// How it works
// - nonzero channel B output mode hands the pin to the compare output
// - complementary B output connects only in PWM modes with mode 01
// - non-PWM B: 00 port, 01 toggle, 10 clear, 11 set on match
// - fast PWM: 01/10 clear on match, set at zero; 11 opposite
// - dual slope 01/10: clear on up-match, set on down-match
// - dual slope 11: set on up-match, clear on down-match
// - force strobes act only while that channel is non-PWM
// - force strobe changes wave and pin as a compare match would
// - mode written with the force strobe is used by the force
// - a forced match never raises the match interrupt
// - force strobe bits read as zero
// - channel A PWM enable puts channel A in PWM operation
// - channel B PWM enable puts channel B in PWM operation
// - inversion bit inverts true and complementary dead-time outputs
// - prescaler clear resets the prescaler only; writing zero does nothing
// - prescaler clear self-clears and always reads zero
// - dead-time prescaler divides by 1, 2, 4 or 8
// - clock select 0 stops; n selects clock divided by 2^(n-1)
// - clock select stop code is the timer enable
// - control C upper nibble shadows the A and B output mode fields
// - PWM off is normal mode; wave mode bits choose the PWM kind
`ifndef FAST_TIMER_MAP_SVH
`define FAST_TIMER_MAP_SVH

`define FT_ADDR_W       4
`define FT_OFF_CTRL_A   4'h0
`define FT_OFF_CTRL_B   4'h1
`define FT_OFF_CTRL_C   4'h2
`define FT_OFF_CTRL_D   4'h3
`define FT_OFF_CMP_A    4'h4
`define FT_OFF_CMP_B    4'h5
`define FT_OFF_CMP_TOP  4'h6
`define FT_OFF_STATUS   4'h7

`define FT_A_MODE_HI    7
`define FT_A_MODE_LO    6
`define FT_B_MODE_HI    5
`define FT_B_MODE_LO    4
`define FT_A_FORCE      3
`define FT_B_FORCE      2
`define FT_A_PWM        1
`define FT_B_PWM        0

`define FT_INVERT       7
`define FT_PS_CLEAR     6
`define FT_DT_HI        5
`define FT_DT_LO        4
`define FT_CS_HI        3
`define FT_CS_LO        0

`define FT_WAVE_HI      1
`define FT_WAVE_LO      0

`define FT_RST_CTRL     8'h00
`define FT_RST_CMP      10'h000
`define FT_RST_TOP      10'h3ff
`define FT_CNT_ZERO     10'h000
`define FT_PS_W         14

`endif

// ==== hw/fast_timer_pkg.sv ====
/*
  Types shared by the fast timer output control block.
  Assumes the constants header sits beside it.
*/
`include "fast_timer_map.svh"
package fast_timer_pkg;
  typedef enum logic [1:0] {
    WAVE_FAST,
    WAVE_DUAL,
    WAVE_SIX_SINGLE,
    WAVE_SIX_DUAL
  } wave_mode_t;
  typedef logic [1:0] outmode_t;
endpackage

// ==== hw/fast_timer_prescaler.sv ====
/*
  Timer clock prescaler: turns a clock-select code into a one-cycle enable.
  Assumes one clock domain; the clear input restarts the divider count.
*/
`timescale 1ns/10ps
`default_nettype none
module fast_timer_prescaler
  import fast_timer_pkg::*;
#(
  parameter int PS_W = `FT_PS_W
) (
  input  wire logic       mclk,    // system clock
  input  wire logic       sys_rst, // async reset, high
  input  wire logic [3:0] clkSel,  // clock select code
  input  wire logic       psClear, // restart the divider
  output logic            tick     // one-cycle timer enable
);
  // refused at elaboration, the stop-to-16384 table needs 14 bits
  if (PS_W < 14) begin : g_width_check
    $error("prescaler too narrow for divide by 16384");
  end

  logic [PS_W-1:0] psCount;
  logic [PS_W-1:0] mask;

  // mask of low bits that must all be one for a tick
  always_comb begin
    mask = '0;
    for (int i = 0; i < PS_W; i++) begin
      if (i + 1 < int'(clkSel)) mask[i] = 1'b1;
    end
  end

  // free running count, cleared without touching the counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      psCount <= '0;
    end else if (psClear || clkSel == 4'h0) begin
      psCount <= '0;
    end else begin
      psCount <= psCount + 1'b1;
    end
  end

  // stop code holds the enable low, others tick every 2^(n-1)
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (clkSel != 4'h0) && !psClear &&
              ((psCount & mask) == mask);
    end
  end
endmodule
`default_nettype wire

// ==== hw/fast_timer_channel.sv ====
/*
  One compare channel's waveform logic: match actions for normal, fast and
  dual-slope modes, plus forced matches.
  Assumes counter, direction and timer enable come from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fast_timer_channel
  import fast_timer_pkg::*;
(
  input  wire logic       mclk,     // system clock
  input  wire logic       sys_rst,  // async reset, high
  input  wire logic       tick,     // timer enable
  input  wire logic       pwmOn,    // channel PWM enable
  input  wire wave_mode_t waveMode, // PWM kind
  input  wire outmode_t   outMode,  // output mode in force this cycle
  input  wire logic       force_,   // force strobe
  input  wire logic       match,    // counter equals compare
  input  wire logic       atZero,   // counter equals zero
  input  wire logic       countUp,  // counting direction
  output logic            wave,     // waveform output
  output logic            matchEvt  // real match, not forced
);
  logic dual;
  logic forceHit;
  assign dual     = (waveMode == WAVE_DUAL) || (waveMode == WAVE_SIX_DUAL);
  assign forceHit = force_ && !pwmOn;

  // forced actions never reach the match event output
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      matchEvt <= 1'b0;
    end else begin
      matchEvt <= tick && match;
    end
  end

  // waveform update, forcing acts as a match in normal mode
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wave <= 1'b0;
    end else if (!pwmOn) begin
      if ((tick && match) || forceHit) begin
        unique case (outMode)
          2'b00: wave <= wave;
          2'b01: wave <= !wave;
          2'b10: wave <= 1'b0;
          2'b11: wave <= 1'b1;
        endcase
      end
    end else if (tick && outMode != 2'b00) begin
      if (!dual) begin
        // match wins over zero when compare is zero
        if (match) begin
          wave <= (outMode == 2'b11);
        end else if (atZero) begin
          wave <= (outMode != 2'b11);
        end
      end else if (match) begin
        if (countUp) begin
          wave <= (outMode == 2'b11);
        end else begin
          wave <= (outMode != 2'b11);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/fast_timer_output_control.sv ====
/*
  Fast timer output control: control registers A to D, compare registers,
  a small 10-bit counter to exercise them, channel A and B waveforms, dead
  time, inversion and pin override.
  Assumes a simple register port with read data one cycle after the strobe
  and a pad that applies the pin enable together with its direction bit.
*/
`timescale 1ns/10ps
`default_nettype none
module fast_timer_output_control
  import fast_timer_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic                 mclk,      // 100 MHz system clock
  input  wire logic                 sys_rst,   // async reset, high
  input  wire logic [`FT_ADDR_W-1:0] regAddr,  // register index
  input  wire logic [7:0]           regWdata,  // write data
  input  wire logic                 regWr,     // write strobe
  input  wire logic                 regRd,     // read strobe
  output logic      [7:0]           regRdata,  // read data, next cycle
  output logic                      chanAPin,  // channel A true output
  output logic                      chanAPinN, // channel A complement
  output logic                      chanBPin,  // channel B true output
  output logic                      chanBPinN, // channel B complement
  output logic                      chanAOe,   // A pin override
  output logic                      chanAOeN,  // A complement connected
  output logic                      chanBOe,   // B pin override
  output logic                      chanBOeN,  // B complement connected
  output logic                      matchIrqA, // A match event pulse
  output logic                      matchIrqB  // B match event pulse
);
  if (CNT_W != 10) begin : g_width_check
    $error("counter width must be 10");
  end

  // control state
  logic [7:0]       ctrlA;
  logic [7:0]       ctrlB;
  logic [3:0]       ctrlCLow;
  logic [1:0]       waveBits;
  logic [CNT_W-1:0] cmpA;
  logic [CNT_W-1:0] cmpB;
  logic [CNT_W-1:0] cmpTop;
  logic [CNT_W-1:0] count;
  logic             countUp;
  logic             psClear;
  logic             tick;
  logic [1:0]       hiByte;
  logic [2:0]       dtCount;
  logic             dtTick;
  logic             wrA;
  logic             wrB;
  logic             wrC;
  logic [7:0]       next_ctrlA;
  outmode_t         modeA;
  outmode_t         modeB;
  wave_mode_t       waveMode;
  logic             waveA;
  logic             waveB;
  logic             evtA;
  logic             evtB;
  logic             dual;
  logic             anyPwm;
  logic             forceA;
  logic             forceB;

  assign wrA = regWr && regAddr == `FT_OFF_CTRL_A;
  assign wrB = regWr && regAddr == `FT_OFF_CTRL_B;
  assign wrC = regWr && regAddr == `FT_OFF_CTRL_C;

  // control A and C share the mode bits, so either write updates them
  always_comb begin
    next_ctrlA = ctrlA;
    if (wrA) begin
      next_ctrlA = regWdata;
    end else if (wrC) begin
      next_ctrlA[7:4] = regWdata[7:4];
    end
    next_ctrlA[`FT_A_FORCE] = 1'b0;
    next_ctrlA[`FT_B_FORCE] = 1'b0;
  end

  // modes seen by a force include the value written alongside it
  assign modeA  = next_ctrlA[`FT_A_MODE_HI:`FT_A_MODE_LO];
  assign modeB  = next_ctrlA[`FT_B_MODE_HI:`FT_B_MODE_LO];
  assign forceA = wrA && regWdata[`FT_A_FORCE];
  assign forceB = wrA && regWdata[`FT_B_FORCE];
  assign waveMode = wave_mode_t'(waveBits);
  assign dual = (waveMode == WAVE_DUAL) || (waveMode == WAVE_SIX_DUAL);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlA <= `FT_RST_CTRL;
    end else begin
      ctrlA <= next_ctrlA;
    end
  end

  // clear bit is held only one cycle, so back-to-back clears work
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlB   <= `FT_RST_CTRL;
      psClear <= 1'b0;
    end else begin
      psClear <= wrB && regWdata[`FT_PS_CLEAR];
      if (wrB) begin
        ctrlB <= regWdata;
        ctrlB[`FT_PS_CLEAR] <= 1'b0;
      end
    end
  end

  // control C low nibble, control D wave bits
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlCLow <= 4'h0;
      waveBits <= 2'b00;
    end else begin
      if (wrC) ctrlCLow <= {regWdata[3:2], 1'b0, regWdata[0]};
      if (regWr && regAddr == `FT_OFF_CTRL_D) begin
        waveBits <= regWdata[`FT_WAVE_HI:`FT_WAVE_LO];
      end
    end
  end

  // 10-bit compares through a shared high byte, written high first
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hiByte <= 2'b00;
      cmpA   <= `FT_RST_CMP;
      cmpB   <= `FT_RST_CMP;
      cmpTop <= `FT_RST_TOP;
    end else if (regWr) begin
      unique case (regAddr)
        `FT_OFF_STATUS:  hiByte <= regWdata[1:0];
        `FT_OFF_CMP_A:   cmpA   <= {hiByte, regWdata};
        `FT_OFF_CMP_B:   cmpB   <= {hiByte, regWdata};
        `FT_OFF_CMP_TOP: cmpTop <= {hiByte, regWdata};
        default: ;
      endcase
    end
  end

  fast_timer_prescaler u_prescaler (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clkSel  (ctrlB[`FT_CS_HI:`FT_CS_LO]),
    .psClear (psClear),
    .tick    (tick)
  );

  // counter runs to the top value, up only or up then down
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count   <= `FT_CNT_ZERO;
      countUp <= 1'b1;
    end else if (tick) begin
      anyPwmStep: begin
        if (anyPwm && dual) begin
          if (countUp) begin
            if (count >= cmpTop) begin
              countUp <= 1'b0;
              count   <= count - 1'b1;
            end else begin
              count <= count + 1'b1;
            end
          end else if (count == `FT_CNT_ZERO) begin
            countUp <= 1'b1;
            count   <= count + 1'b1;
          end else begin
            count <= count - 1'b1;
          end
        end else begin
          countUp <= 1'b1;
          count   <= (count >= cmpTop) ? `FT_CNT_ZERO : count + 1'b1;
        end
      end
    end
  end

  assign anyPwm = ctrlA[`FT_A_PWM] || ctrlA[`FT_B_PWM];

  fast_timer_channel u_chan_a (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .tick     (tick),
    .pwmOn    (ctrlA[`FT_A_PWM]),
    .waveMode (waveMode),
    .outMode  (modeA),
    .force_   (forceA),
    .match    (count == cmpA),
    .atZero   (count == `FT_CNT_ZERO),
    .countUp  (countUp),
    .wave     (waveA),
    .matchEvt (evtA)
  );

  fast_timer_channel u_chan_b (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .tick     (tick),
    .pwmOn    (ctrlA[`FT_B_PWM]),
    .waveMode (waveMode),
    .outMode  (modeB),
    .force_   (forceB),
    .match    (count == cmpB),
    .atZero   (count == `FT_CNT_ZERO),
    .countUp  (countUp),
    .wave     (waveB),
    .matchEvt (evtB)
  );

  // dead-time clock: timer tick divided by 1, 2, 4 or 8
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dtCount <= 3'h0;
      dtTick  <= 1'b0;
    end else begin
      dtTick <= 1'b0;
      if (tick) begin
        dtCount <= dtCount + 3'h1;
        unique case (ctrlB[`FT_DT_HI:`FT_DT_LO])
          2'b00: dtTick <= 1'b1;
          2'b01: dtTick <= dtCount[0];
          2'b10: dtTick <= &dtCount[1:0];
          2'b11: dtTick <= &dtCount;
        endcase
      end
    end
  end

  // pins: true and complement, inverted on request, complement always driven,
  // its enable only in PWM with mode 01; dead-time insertion itself lies outside
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chanAPin  <= 1'b0;
      chanAPinN <= 1'b0;
      chanBPin  <= 1'b0;
      chanBPinN <= 1'b0;
    end else begin
      chanAPin  <= waveA ^ ctrlB[`FT_INVERT];
      chanAPinN <= !waveA ^ ctrlB[`FT_INVERT];
      chanBPin  <= waveB ^ ctrlB[`FT_INVERT];
      chanBPinN <= !waveB ^ ctrlB[`FT_INVERT];
    end
  end

  // override enables; direction bit stays with software and the pad
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chanAOe  <= 1'b0;
      chanAOeN <= 1'b0;
      chanBOe  <= 1'b0;
      chanBOeN <= 1'b0;
    end else begin
      chanAOe  <= |ctrlA[`FT_A_MODE_HI:`FT_A_MODE_LO];
      chanAOeN <= ctrlA[`FT_A_PWM] &&
                  ctrlA[`FT_A_MODE_HI:`FT_A_MODE_LO] == 2'b01;
      chanBOe  <= |ctrlA[`FT_B_MODE_HI:`FT_B_MODE_LO];
      chanBOeN <= ctrlA[`FT_B_PWM] &&
                  ctrlA[`FT_B_MODE_HI:`FT_B_MODE_LO] == 2'b01;
    end
  end

  // match events straight from the channels, forced ones excluded
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      matchIrqA <= 1'b0;
      matchIrqB <= 1'b0;
    end else begin
      matchIrqA <= evtA;
      matchIrqB <= evtB;
    end
  end

  // read port; clear and force bits always read zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `FT_OFF_CTRL_A:  regRdata <= ctrlA;
        `FT_OFF_CTRL_B:  regRdata <= ctrlB;
        `FT_OFF_CTRL_C:  regRdata <= {ctrlA[7:4], ctrlCLow};
        `FT_OFF_CTRL_D:  regRdata <= {6'h00, waveBits};
        `FT_OFF_CMP_A:   regRdata <= cmpA[7:0];
        `FT_OFF_CMP_B:   regRdata <= cmpB[7:0];
        `FT_OFF_CMP_TOP: regRdata <= cmpTop[7:0];
        `FT_OFF_STATUS:  regRdata <= {countUp, dtTick, 4'h0, count[9:8]};
        default:         regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ==== test/power_stage_model.sv ====
/*
  Load model on channel B's true output: a power stage behind a pad.
  Assumes the bench drives the pad direction bit like software would.
*/
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  input  wire logic ddrB,  // pad direction bit
  input  wire logic pinB,  // true waveform
  input  wire logic oeB,   // compare output override
  output logic      loadB  // level seen at the load
);
  // pulled down when undriven, so a missing enable reads as low
  assign loadB = (ddrB && oeB) ? pinB : 1'b0;
endmodule
`default_nettype wire

// ==== test/fast_timer_output_control_assertions.sv ====
/*
  Port assertions for the fast timer output control block.
  Assumes the register map header and package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fast_timer_map.svh"
module fast_timer_output_control_assertions
  import fast_timer_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic                  mclk,      // clock
  input wire logic                  sys_rst,   // reset, high
  input wire logic [`FT_ADDR_W-1:0] regAddr,   // register index
  input wire logic [7:0]            regWdata,  // write data
  input wire logic                  regWr,     // write strobe
  input wire logic                  regRd,     // read strobe
  input wire logic [7:0]            regRdata,  // read data
  input wire logic                  chanAPin,  // A true
  input wire logic                  chanAPinN, // A complement
  input wire logic                  chanBPin,  // B true
  input wire logic                  chanBPinN, // B complement
  input wire logic                  chanAOe,   // A override
  input wire logic                  chanAOeN,  // A complement on
  input wire logic                  chanBOe,   // B override
  input wire logic                  chanBOeN,  // B complement on
  input wire logic                  matchIrqA, // A match pulse
  input wire logic                  matchIrqB  // B match pulse
);
  logic invertBit;
  logic ctrlWr;
  // writes that can move the mode fields
  assign ctrlWr = regWr && (regAddr == `FT_OFF_CTRL_A ||
                            regAddr == `FT_OFF_CTRL_C);
  // inversion tracked here so pin checks know the polarity
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      invertBit <= 1'b0;
    end else if (regWr && regAddr == `FT_OFF_CTRL_B) begin
      invertBit <= regWdata[7];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_idle_read_zero: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_force_reads_zero: assert property (
    regRd && regAddr == `FT_OFF_CTRL_A |=> regRdata[3:2] == 2'b00)
    else $error("force bits read back nonzero");
  chk_ctrlb_readback: assert property (
    regWr && regAddr == `FT_OFF_CTRL_B ##1 !regWr
    ##1 regRd && regAddr == `FT_OFF_CTRL_B
    |=> regRdata == ($past(regWdata, 3) & 8'hbf))
    else $error("control B readback wrong");
  chk_shadow_modes: assert property (
    regWr && regAddr == `FT_OFF_CTRL_A ##1 !regWr
    ##1 regRd && regAddr == `FT_OFF_CTRL_C
    |=> regRdata[7:4] == $past(regWdata[7:4], 3))
    else $error("control C nibble not a shadow of mode fields");
  chk_b_override: assert property (
    regWr && regAddr == `FT_OFF_CTRL_A ##1 (!ctrlWr)[*3]
    |-> chanBOe == ($past(regWdata[5:4], 3) != 2'b00))
    else $error("B pin override wrong for mode field");
  chk_b_compl_link: assert property (
    regWr && regAddr == `FT_OFF_CTRL_A ##1 (!ctrlWr)[*3]
    |-> chanBOeN == ($past(regWdata[0], 3) &&
                     $past(regWdata[5:4], 3) == 2'b01))
    else $error("B complement connection wrong");
  chk_force_b_set: assert property (
    regWr && regAddr == `FT_OFF_CTRL_A && regWdata[5:0] == 6'h34
    ##1 (!regWr)[*3] |-> chanBPin == !invertBit)
    else $error("forced set did not set B");
  chk_force_b_clear: assert property (
    regWr && regAddr == `FT_OFF_CTRL_A && regWdata[5:0] == 6'h24
    ##1 (!regWr)[*3] |-> chanBPin == invertBit)
    else $error("forced clear did not clear B");
  cover property (regWr && regAddr == `FT_OFF_CTRL_A && regWdata[2]);
  cover property (regRd && regAddr == `FT_OFF_CTRL_C);
  cover property (matchIrqB);
endmodule
bind fast_timer_output_control fast_timer_output_control_assertions #(
  .CNT_W(CNT_W)
) chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .chanAPin(chanAPin), .chanAPinN(chanAPinN),
  .chanBPin(chanBPin), .chanBPinN(chanBPinN), .chanAOe(chanAOe),
  .chanAOeN(chanAOeN), .chanBOe(chanBOe), .chanBOeN(chanBOeN),
  .matchIrqA(matchIrqA), .matchIrqB(matchIrqB)
);
`default_nettype wire

// ==== test/fast_timer_output_control_test.sv ====
/*
  Self-checking bench for the fast timer output control block.
  Assumes the checker binds itself and the load model sits on channel B.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fast_timer_map.svh"
module fast_timer_output_control_test;
  import fast_timer_pkg::*;
  logic mclk, sys_rst, regWr, regRd, ddrB, loadB;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic aPin, aPinN, bPin, bPinN, aOe, aOeN, bOe, bOeN, irqA, irqB;
  int errors, samplesChecked;
  outmode_t forceSeq [5] = '{2'b10, 2'b11, 2'b01, 2'b01, 2'b00};
  fast_timer_output_control dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .chanAPin(aPin), .chanAPinN(aPinN),
    .chanBPin(bPin), .chanBPinN(bPinN), .chanAOe(aOe), .chanAOeN(aOeN),
    .chanBOe(bOe), .chanBOeN(bOeN), .matchIrqA(irqA), .matchIrqB(irqB)
  );
  power_stage_model stage_u (
    .ddrB(ddrB), .pinB(bPin), .oeB(bOe), .loadB(loadB)
  );
  always #5 mclk = ~mclk;
  // normal mode compare action on the wave
  function automatic logic expWave(input logic prev, input outmode_t m);
    case (m)
      2'b01: return ~prev;
      2'b10: return 1'b0;
      2'b11: return 1'b1;
      default: return prev;
    endcase
  endfunction
  // fast pwm high ticks over two periods, scaled by the clock divider
  function automatic int expHigh(input outmode_t m, input int c, input int t,
                                 input int cs);
    return (2 * ((m == 2'b11) ? t + 1 - c : c)) << (cs - 1);
  endfunction
  task automatic conclude;
    $display("compared %0d, mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic cmpReg(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: register %h, want %h", $time, got, exp);
    end
  endtask
  task automatic cmpPin(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: pin %b, want %b", $time, got, exp);
    end
  endtask
  task automatic cmpCount(input int got, input int exp);
    samplesChecked++;
    if (got != exp) begin
      errors++;
      $display("mismatch at %0t: count %0d, want %0d", $time, got, exp);
    end
  endtask
  // window lengths are whole periods, so phase does not matter
  task automatic countHigh(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge mclk);
      #1 hi += (loadB === 1'b1);
    end
  endtask
  // watchdog: a hang ends in the closing report
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    conclude();
  end
  initial begin
    logic [7:0] d, m;
    logic w;
    int hi, h2, h3;
    mclk = 0; sys_rst = 1; regAddr = 0; regWdata = 0;
    regWr = 0; regRd = 0; ddrB = 0;
    d = $urandom(32'h54a1);
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(i[3:0], d);
      cmpReg(d, `FT_RST_CTRL);
    end
    // random mode fields and control B values, read back
    for (int i = 0; i < 8; i++) begin
      m = $urandom;
      m[1:0] = 2'b00;
      wr(`FT_OFF_CTRL_A, m);
      rd(`FT_OFF_CTRL_C, d);
      cmpReg(d & 8'hf0, m & 8'hf0);
      rd(`FT_OFF_CTRL_A, d);
      cmpReg(d, m & 8'hf3);
      m = $urandom;
      wr(`FT_OFF_CTRL_B, m);
      rd(`FT_OFF_CTRL_B, d);
      cmpReg(d, m & 8'hbf);
    end
    // timer stopped: forced matches walk the normal mode table
    wr(`FT_OFF_CTRL_B, 8'h00);
    ddrB <= 1'b1;
    w = 1'b0;
    foreach (forceSeq[i]) begin
      wr(`FT_OFF_CTRL_A, {2'b00, forceSeq[i], 4'b0100});
      w = expWave(w, forceSeq[i]);
      repeat (3) @(posedge mclk);
      #1 cmpPin(loadB, w && forceSeq[i] != 2'b00);
      cmpPin(irqB, 1'b0);
    end
    // channel A: forced set with mode 11, no pwm
    wr(`FT_OFF_CTRL_A, 8'hc8);
    repeat (3) @(posedge mclk);
    #1 cmpPin(aPin, 1'b1);
    cmpPin(aPinN, 1'b0);
    cmpPin(aOe, 1'b1);
    cmpPin(aOeN, 1'b0);
    cmpPin(irqA, 1'b0);
    wr(`FT_OFF_CTRL_A, 8'h34);
    wr(`FT_OFF_CTRL_B, 8'h80);
    repeat (3) @(posedge mclk);
    #1 cmpPin(loadB, 1'b0);
    cmpPin(bPinN, 1'b1);
    wr(`FT_OFF_CTRL_B, 8'h00);
    // pwm on: force ignored, complement only with mode 01
    // enable is set first so the force meets an enable already held
    wr(`FT_OFF_CTRL_A, 8'h21);
    wr(`FT_OFF_CTRL_A, 8'h25);
    repeat (3) @(posedge mclk);
    #1 cmpPin(loadB, 1'b1);
    cmpPin(bOeN, 1'b0);
    wr(`FT_OFF_CTRL_A, 8'h11);
    repeat (3) @(posedge mclk);
    #1 cmpPin(bOeN, 1'b1);
    // fast pwm, compare 3, top 7, at three clock rates
    wr(`FT_OFF_STATUS, 8'h00);
    wr(`FT_OFF_CMP_B, 8'h03);
    wr(`FT_OFF_STATUS, 8'h00);
    wr(`FT_OFF_CMP_TOP, 8'h07);
    wr(`FT_OFF_CTRL_D, 8'h00);
    for (int cs = 1; cs <= 3; cs++) begin
      for (int k = 2; k <= 3; k++) begin
        wr(`FT_OFF_CTRL_A, {2'b00, k[1:0], 4'b0001});
        wr(`FT_OFF_CTRL_B, {4'h0, cs[3:0]});
        repeat (40) @(posedge mclk);
        countHigh(16 << (cs - 1), hi);
        cmpCount(hi, expHigh(k[1:0], 3, 7, cs));
      end
    end
    wr(`FT_OFF_CTRL_B, 8'h00);
    repeat (8) @(posedge mclk);
    countHigh(16, hi);
    cmpCount(hi % 16, 0);
    // dual slope: modes 10 and 11 are complements, 10 the shorter
    wr(`FT_OFF_CTRL_D, 8'h01);
    wr(`FT_OFF_CTRL_B, 8'h01);
    wr(`FT_OFF_CTRL_A, 8'h21);
    repeat (40) @(posedge mclk);
    countHigh(112, h2);
    wr(`FT_OFF_CTRL_A, 8'h31);
    repeat (40) @(posedge mclk);
    countHigh(112, h3);
    cmpCount(h2 + h3, 112);
    cmpCount(int'(h2 < h3), 1);
    // dead-time tick rate from back-to-back status reads
    for (int dt = 0; dt < 4; dt++) begin
      wr(`FT_OFF_CTRL_B, {2'b00, dt[1:0], 4'h1});
      @(posedge mclk);
      regAddr <= `FT_OFF_STATUS;
      regRd <= 1'b1;
      hi = 0;
      repeat (16) begin
        @(posedge mclk);
        #1 hi += (regRdata[6] === 1'b1);
      end
      @(posedge mclk);
      regRd <= 1'b0;
      cmpCount(hi, 16 >> dt);
    end
    conclude();
  end
endmodule
`default_nettype wire
